// file: ssos_consts.vh
// Constants of the speed and current output scaler
`ifndef SSOS_CONSTS_VH
`define SSOS_CONSTS_VH
// Register byte offsets
`define SSOS_OFF_CTRL   8'h00
`define SSOS_OFF_CAL    8'h04
`define SSOS_OFF_OFFS   8'h08
`define SSOS_OFF_TAU    8'h0C
`define SSOS_OFF_VMAX   8'h10
`define SSOS_OFF_VMIN   8'h14
`define SSOS_OFF_BRK    8'h18
`define SSOS_OFF_STILL  8'h1C
`define SSOS_OFF_STAT   8'h20
// Control field positions
`define SSOS_CHAR_LSB   0
`define SSOS_CHAR_MSB   1
`define SSOS_RNG_LSB    2
`define SSOS_RNG_MSB    3
`define SSOS_SUPP_BIT   4
`define SSOS_BRKEN_BIT  5
`define SSOS_VOTED_BIT  6
// Characteristic codes
`define SSOS_CHAR_OFF   2'h0
`define SSOS_CHAR_SPEED 2'h1
`define SSOS_CHAR_ACCEL 2'h2
// Reset values
`define SSOS_CTRL_RST   7'h05
`define SSOS_CAL_RST    16'h4000
`define SSOS_OFFS_RST   16'h0000
`define SSOS_TAU_RST    8'h00
`define SSOS_VMAX_RST   16'h0EA6
`define SSOS_VMIN_RST   16'h0000
`define SSOS_BRKV_RST   16'h0001
`define SSOS_BRKI_RST   16'h0FA1
`define SSOS_STILL_RST  16'h005A
// Currents in microamps, calibration in units of 1/16384
`define SSOS_FULL_UA    20000
`define SSOS_LIVE_UA    4000
`define SSOS_OFFS_MAX   10000
`define SSOS_BRKI_MIN   16'h0FA1
`define SSOS_BRKI_MAX   16'h4E1F
`define SSOS_CAL_SHIFT  14
`define SSOS_CAL_MIN    16'h399A
`define SSOS_CAL_MAX    16'h4666
// Timing
`define SSOS_CLK_HZ     125000000
`define SSOS_STILL_UNIT_S 1
`define SSOS_TAU_UNIT_MS 100
`define SSOS_FILT_SHIFT 10
`endif

// file: ssos_tick.v
// Restartable divider giving a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module ssos_tick #(
  parameter CYCLES = 1000
) (
  input  wire pclk,
  input  wire presetn,
  input  wire clr,
  output reg  tick
);
  reg [31:0] cnt_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 32'h00000000;
      tick    <= 1'b0;
    end
    else if (clr)
    begin
      cnt_reg <= 32'h00000000;
      tick    <= 1'b0;
    end
    else if (cnt_reg == CYCLES - 1)
    begin
      cnt_reg <= 32'h00000000;
      tick    <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 32'h00000001;
      tick    <= 1'b0;
    end
  end
endmodule // ssos_tick
`default_nettype wire

// file: ssos_smooth.v
// First-order exponential smoothing of the current setpoint
`timescale 1ns/1ps
`default_nettype none
`include "ssos_consts.vh"
module ssos_smooth (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        step,
  input  wire [7:0]  tau,
  input  wire        load,
  input  wire [15:0] x,
  output wire [15:0] y
);
  reg        [25:0] acc_reg;
  reg        [7:0]  div_reg;
  wire signed [26:0] diff;
  wire signed [26:0] nudge;

  assign diff = $signed({1'b0, x, 10'h000}) - $signed({1'b0, acc_reg});
  // Arithmetic shift keeps falling steps negative
  assign nudge = diff >>> 10;
  assign y    = acc_reg[25:10];

  // ==========================================
  // Filter state
  // One update per tau steps; 1/1024 gain keeps 63 % at one tau
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg <= 26'h0000000;
      div_reg <= 8'h00;
    end
    else if (load)
    begin
      acc_reg <= 26'h0000000;
      div_reg <= 8'h00;
    end
    else if (tau == 8'h00)
    begin
      acc_reg <= {x, 10'h000};
      div_reg <= 8'h00;
    end
    else if (step)
    begin
      if (div_reg >= tau - 8'h01)
      begin
        div_reg <= 8'h00;
        acc_reg <= acc_reg + nudge[25:0];
      end
      else
        div_reg <= div_reg + 8'h01;
    end
  end
endmodule // ssos_smooth
`default_nettype wire

// file: ssos_top.v
// Speed monitor channel: standstill, backplane check and current setpoint
// How it works
// - Standstill is raised once the set number of seconds passes with no input pulse.
// - Any input pulse clears standstill at once.
// - A backplane type mismatch raises relay fault and drops channel ok.
// - Characteristic off or code 3 disables the output, otherwise speed or acceleration drives it.
// - Four ranges exist: 0-20, 4-20, 20-0 and 20-4 mA.
// - Suppression can be set only while a 4 mA based range is chosen.
// - With suppression on and channel not ok the setpoint is 0 mA.
// - A calibration factor from 0.9 to 1.1 scales the slope.
// - A signed offset of up to 10 mA is added to the setpoint.
// - The setpoint is smoothed with a time constant of 0 to 25.5 s, zero meaning none.
// - A suppressed fault bypasses smoothing and zeroes the output at once.
// - Acceleration maps symmetrically about zero onto the range midpoint.
// - Speed maps linearly from minimum speed to maximum speed over the range.
// - The break point splits the speed curve into two segments joined at a set point.
// - The break point is ignored in acceleration mode.
`timescale 1ns/1ps
`default_nettype none
`include "ssos_consts.vh"
module ssos_top #(
  parameter SEC_CYCLES  = `SSOS_CLK_HZ * `SSOS_STILL_UNIT_S,
  parameter FILT_CYCLES = `SSOS_CLK_HZ / 1000 * `SSOS_TAU_UNIT_MS / 1024
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire        pulse_in,
  input  wire [15:0] speed_in,
  input  wire [15:0] accel_in,
  input  wire        backplane_voted_in,
  input  wire        channel_fault_in,
  output reg         standstill,
  output reg         relay_fault,
  output reg         channel_ok,
  output reg         iout_en,
  output reg  [15:0] iout_ua
);

  // ==========================================
  // Helpers
  function [31:0] ssos_scale;
    input [31:0] num;
    input [31:0] span;
    input [31:0] den;
    begin
      if (den == 32'h00000000)
        ssos_scale = span;
      else
        ssos_scale = (num * span) / den;
    end
  endfunction

  function [15:0] ssos_clamp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < lo)
        ssos_clamp = lo;
      else if (v > hi)
        ssos_clamp = hi;
      else
        ssos_clamp = v;
    end
  endfunction

  // ==========================================
  // Registers
  reg [6:0]  ctrl_reg;
  reg [15:0] cal_reg;
  reg [15:0] offs_reg;
  reg [7:0]  tau_reg;
  reg [15:0] vmax_reg;
  reg [15:0] vmin_reg;
  reg [15:0] brkv_reg;
  reg [15:0] brki_reg;
  reg [15:0] still_reg;
  reg [15:0] sec_reg;
  reg [15:0] setp_reg;

  wire [1:0] char_sel = ctrl_reg[`SSOS_CHAR_MSB:`SSOS_CHAR_LSB];
  wire [1:0] rng      = ctrl_reg[`SSOS_RNG_MSB:`SSOS_RNG_LSB];
  wire       live     = rng[0];
  wire       invert   = rng[1];
  // only with a 4 mA based range
  wire       supp_on  = ctrl_reg[`SSOS_SUPP_BIT] & live;
  wire       brk_on   = ctrl_reg[`SSOS_BRKEN_BIT] & (char_sel == `SSOS_CHAR_SPEED);

  wire        wr_en  = psel & penable & pwrite;
  wire        setup  = psel & ~penable;
  wire signed [15:0] offs_in = pwdata[15:0];

  function mapped;
    input [7:0] a;
    begin
      mapped = (a <= `SSOS_OFF_STAT) && (a[1:0] == 2'b00);
    end
  endfunction

  assign pready = 1'b1;

  // ==========================================
  // APB write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg  <= `SSOS_CTRL_RST;
      cal_reg   <= `SSOS_CAL_RST;
      offs_reg  <= `SSOS_OFFS_RST;
      tau_reg   <= `SSOS_TAU_RST;
      vmax_reg  <= `SSOS_VMAX_RST;
      vmin_reg  <= `SSOS_VMIN_RST;
      brkv_reg  <= `SSOS_BRKV_RST;
      brki_reg  <= `SSOS_BRKI_RST;
      still_reg <= `SSOS_STILL_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        `SSOS_OFF_CTRL:
        begin
          ctrl_reg <= pwdata[6:0];
          // suppression refused on 0 based ranges
          ctrl_reg[`SSOS_SUPP_BIT] <= pwdata[`SSOS_SUPP_BIT] & pwdata[`SSOS_RNG_LSB];
        end
        // factor held within 0.9 .. 1.1
        `SSOS_OFF_CAL:
          cal_reg <= ssos_clamp(pwdata[15:0], `SSOS_CAL_MIN, `SSOS_CAL_MAX);
        `SSOS_OFF_OFFS:
        begin
          if (offs_in > 16'sd10000)
            offs_reg <= 16'd10000;
          else if (offs_in < -16'sd10000)
            offs_reg <= -16'sd10000;
          else
            offs_reg <= pwdata[15:0];
        end
        `SSOS_OFF_TAU:
          tau_reg <= pwdata[7:0];
        `SSOS_OFF_VMAX:
          vmax_reg <= pwdata[15:0];
        `SSOS_OFF_VMIN:
          vmin_reg <= pwdata[15:0];
        // break current 4.001 .. 19.999 mA
        `SSOS_OFF_BRK:
        begin
          brkv_reg <= pwdata[15:0];
          brki_reg <= ssos_clamp(pwdata[31:16], `SSOS_BRKI_MIN, `SSOS_BRKI_MAX);
        end
        `SSOS_OFF_STILL:
          still_reg <= pwdata[15:0];
        default:
          ;
      endcase
    end
  end

  // ==========================================
  // APB read, answered in the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= ~mapped(paddr);
      case (paddr)
        `SSOS_OFF_CTRL:  prdata <= {25'h0000000, ctrl_reg};
        `SSOS_OFF_CAL:   prdata <= {16'h0000, cal_reg};
        `SSOS_OFF_OFFS:  prdata <= {{16{offs_reg[15]}}, offs_reg};
        `SSOS_OFF_TAU:   prdata <= {24'h000000, tau_reg};
        `SSOS_OFF_VMAX:  prdata <= {16'h0000, vmax_reg};
        `SSOS_OFF_VMIN:  prdata <= {16'h0000, vmin_reg};
        `SSOS_OFF_BRK:   prdata <= {brki_reg, brkv_reg};
        `SSOS_OFF_STILL: prdata <= {16'h0000, still_reg};
        `SSOS_OFF_STAT:
          prdata <= {iout_ua, 12'h000, iout_en, channel_ok, relay_fault, standstill};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================
  // Standstill timer
  wire sec_tick;

  // Divider restarts on a pulse so the wait is exact
  ssos_tick #(
    .CYCLES (SEC_CYCLES)
  ) u_sec (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (pulse_in),
    .tick    (sec_tick)
  );

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_reg    <= 16'h0000;
      standstill <= 1'b0;
    end
    else if (pulse_in)
    begin
      sec_reg    <= 16'h0000;
      standstill <= 1'b0;
    end
    else
    begin
      if (sec_tick && sec_reg != 16'hFFFF)
        sec_reg <= sec_reg + 16'h0001;
      if (sec_reg >= still_reg)
        standstill <= 1'b1;
    end
  end

  // ==========================================
  // Backplane check
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      relay_fault <= 1'b0;
      channel_ok  <= 1'b0;
    end
    else
    begin
      relay_fault <= ctrl_reg[`SSOS_VOTED_BIT] ^ backplane_voted_in;
      channel_ok  <= ~(ctrl_reg[`SSOS_VOTED_BIT] ^ backplane_voted_in) & ~channel_fault_in;
    end
  end

  // ==========================================
  // Setpoint arithmetic
  reg        [31:0] start, full, half, pos, bpos, mag, dlt;
  reg signed [31:0] amp;
  wire       [31:0] v    = {16'h0000, speed_in};
  wire       [31:0] mn   = {16'h0000, vmin_reg};
  wire       [31:0] mx   = {16'h0000, vmax_reg};
  wire       [31:0] bs   = {16'h0000, brkv_reg};
  wire       [31:0] amax = {16'h0000, vmax_reg};

  always @*
  begin
    start = live ? `SSOS_LIVE_UA : 32'h00000000;
    full  = `SSOS_FULL_UA - start;
    half  = full >> 1;
    bpos  = {16'h0000, brki_reg} - start;
    mag   = accel_in[15] ? {16'h0000, ~accel_in + 16'h0001} : {16'h0000, accel_in};
    dlt   = 32'h00000000;
    pos   = 32'h00000000;
    if (char_sel == `SSOS_CHAR_ACCEL)
    begin
      if (mag >= amax)
        dlt = half;
      else
        dlt = ssos_scale(mag, half, amax);
      pos = accel_in[15] ? half - dlt : half + dlt;
    end
    else if (v <= mn)
      pos = 32'h00000000;
    else if (v >= mx)
      pos = full;
    // two segments joined at the break
    else if (brk_on)
    begin
      if (v <= bs)
        pos = ssos_scale(v - mn, bpos, (bs > mn) ? bs - mn : 32'h00000000);
      else
        pos = bpos + ssos_scale(v - bs, full - bpos, mx - bs);
    end
    else
      pos = ssos_scale(v - mn, full, mx - mn);
    pos = (pos * {16'h0000, cal_reg}) >> `SSOS_CAL_SHIFT;
    amp = invert ? $signed(`SSOS_FULL_UA - pos) : $signed(start + pos);
    amp = amp + {{16{offs_reg[15]}}, offs_reg};
    if (amp < 0)
      amp = 0;
    else if (amp > `SSOS_FULL_UA)
      amp = `SSOS_FULL_UA;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      setp_reg <= 16'h0000;
    else
      setp_reg <= amp[15:0];
  end

  // ==========================================
  // Smoothing and output
  wire        filt_tick;
  wire [15:0] smooth_ua;
  wire        kill = supp_on & ~channel_ok;

  ssos_tick #(
    .CYCLES (FILT_CYCLES)
  ) u_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (1'b0),
    .tick    (filt_tick)
  );

  ssos_smooth u_smooth (
    .pclk    (pclk),
    .presetn (presetn),
    .step    (filt_tick),
    .tau     (tau_reg),
    .load    (kill),
    .x       (setp_reg),
    .y       (smooth_ua)
  );

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      iout_en <= 1'b0;
      iout_ua <= 16'h0000;
    end
    else if (char_sel == `SSOS_CHAR_OFF || char_sel == 2'h3)
    begin
      iout_en <= 1'b0;
      iout_ua <= 16'h0000;
    end
    else if (kill)
    begin
      iout_en <= 1'b1;
      iout_ua <= 16'h0000;
    end
    else
    begin
      iout_en <= 1'b1;
      iout_ua <= smooth_ua;
    end
  end

endmodule // ssos_top
`default_nettype wire

// file: ssos_chk.sv
// Assertion checker for the scaler top ports
`timescale 1ns/1ps
`default_nettype none
module ssos_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pulse_in,
  input wire logic        standstill,
  input wire logic        relay_fault,
  input wire logic        channel_ok,
  input wire logic [15:0] iout_ua
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ========================================
  // Bus
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad;
    psel && !penable && (paddr > 8'h20 || paddr[1:0] != 2'h0);
  endsequence
  sequence s_good;
    psel && !penable && paddr <= 8'h20 && paddr[1:0] == 2'h0;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_bad: assert property (s_bad |=> pslverr)
    else $error("no error on unmapped access");
  a_err_good: assert property (s_good |=> !pslverr)
    else $error("error on mapped access");
  // Data must not move once the access phase is under way
  a_rdata_hold: assert property (s_setup ##1 penable |=> $stable(prdata) && $stable(pslverr))
    else $error("read data moved after access");
  // ========================================
  // Channel
  a_pulse_clear: assert property (pulse_in |=> !standstill)
    else $error("standstill kept after pulse");
  a_still_rise: assert property ($rose(standstill) |-> !$past(pulse_in))
    else $error("standstill raised on a pulse");
  a_still_hold: assert property (standstill && !pulse_in |=> standstill)
    else $error("standstill dropped without pulse");
  a_fault_ok: assert property (relay_fault |-> !channel_ok)
    else $error("channel ok during relay fault");
  a_ua_max: assert property (iout_ua <= 16'h4E20)
    else $error("setpoint above range end");
endmodule // ssos_chk
bind ssos_top ssos_chk chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in),
  .standstill(standstill), .relay_fault(relay_fault), .channel_ok(channel_ok),
  .iout_ua(iout_ua)
);
`default_nettype wire

// file: ssos_drv_model.sv
// Behavioural current driver stage behind the scaler
`timescale 1ns/1ps
`default_nettype none
module ssos_drv_model (
  input  wire logic        pclk,
  input  wire logic        en,
  input  wire logic [15:0] ua,
  output var  logic [15:0] loop_ua
);
  // Disabled stage sources no current at all
  always @(posedge pclk)
  begin
    loop_ua <= en ? ua : 16'h0000;
  end
endmodule // ssos_drv_model
`default_nettype wire

// file: speed_current_output_scaler_bench.sv
// Self-checking bench for the speed and current output scaler
`timescale 1ns/1ps
`default_nettype none
`include "ssos_consts.vh"
module speed_current_output_scaler_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic        pulse_in, bp_voted, ch_fault, standstill, relay_fault, channel_ok, iout_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [15:0] speed, accel, iout_ua, loop_ua;
  int          err_count, num_checks;
  // Short counts keep the run small
  ssos_top #(.SEC_CYCLES(100), .FILT_CYCLES(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_in(pulse_in), .speed_in(speed), .accel_in(accel),
    .backplane_voted_in(bp_voted), .channel_fault_in(ch_fault),
    .standstill(standstill), .relay_fault(relay_fault), .channel_ok(channel_ok),
    .iout_en(iout_en), .iout_ua(iout_ua)
  );
  ssos_drv_model drv_u (.pclk(pclk), .en(iout_en), .ua(iout_ua), .loop_ua(loop_ua));
  // ========================================
  // Helpers
  task report_and_stop;
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a hung access
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask
  // Voted backplane is installed, so the voted bit rides along
  task ctrl(input logic [6:0] c);
    wr(`SSOS_OFF_CTRL, {25'h0, c | 7'h40});
  endtask
  // Loop current after the three-edge setpoint path, with rounding slack
  task near(input int e, input int t);
    repeat (6) @(posedge pclk);
    num_checks++;
    if ($isunknown(loop_ua) || loop_ua + t < e || loop_ua > e + t)
    begin
      err_count++;
      $display("[ERR] %0t current %0d expected %0d", $time, loop_ua, e);
    end
  endtask
  // ========================================
  // Scenarios
  task t_regs;
    rd(`SSOS_OFF_CTRL, 32'h5);
    rd(`SSOS_OFF_CAL, 32'h4000);
    rd(`SSOS_OFF_VMAX, 32'hEA6);
    rd(`SSOS_OFF_BRK, 32'h0FA10001);
    rd(`SSOS_OFF_STILL, 32'h5A);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    wr(`SSOS_OFF_STAT, 32'hFFFFFFFF);
    chk({31'h0, err_q}, 32'h0);
  endtask
  task t_still;
    wr(`SSOS_OFF_STILL, 32'h2);
    pulse_in <= 1'b1;
    @(posedge pclk);
    pulse_in <= 1'b0;
    repeat (150) @(posedge pclk);
    chk({31'h0, standstill}, 32'h0);
    repeat (70) @(posedge pclk);
    chk({31'h0, standstill}, 32'h1);
    pulse_in <= 1'b1;
    @(posedge pclk);
    pulse_in <= 1'b0;
    @(posedge pclk);
    chk({31'h0, standstill}, 32'h0);
  endtask
  task t_backplane;
    bp_voted <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({30'h0, relay_fault, channel_ok}, 32'h2);
    ctrl(7'h05);
    repeat (4) @(posedge pclk);
    chk({30'h0, relay_fault, channel_ok}, 32'h1);
  endtask
  task t_speed;
    static int exp_ua[4] = '{5000, 8000, 15000, 16000};
    wr(`SSOS_OFF_VMAX, 32'hFA0);
    speed <= 16'h3E8;
    for (int r = 0; r < 4; r++)
    begin
      ctrl(7'h01 | 7'(r << 2));
      near(exp_ua[r], 2);
    end
    speed <= 16'h1388;
    ctrl(7'h01);
    near(20000, 0);
    ctrl(7'h00);
    near(0, 0);
    chk({31'h0, iout_en}, 32'h0);
    wr(`SSOS_OFF_VMIN, 32'h3E8);
    speed <= 16'h9C4;
    ctrl(7'h01);
    near(10000, 2);
    speed <= 16'h1F4;
    near(0, 0);
    wr(`SSOS_OFF_VMIN, 32'h0);
  endtask
  task t_cal;
    speed <= 16'h3E8;
    ctrl(7'h01);
    wr(`SSOS_OFF_CAL, 32'h4666);
    near(5500, 3);
    wr(`SSOS_OFF_CAL, 32'h0);
    rd(`SSOS_OFF_CAL, 32'h399A);
    near(4500, 3);
    wr(`SSOS_OFF_CAL, 32'h4000);
    wr(`SSOS_OFF_OFFS, 32'h3E8);
    near(6000, 2);
    wr(`SSOS_OFF_OFFS, 32'hFFFFFC18);
    near(4000, 2);
    wr(`SSOS_OFF_OFFS, 32'h0);
  endtask
  task t_break;
    wr(`SSOS_OFF_BRK, 32'h2EE003E8);
    ctrl(7'h25);
    speed <= 16'h1F4;
    near(8000, 2);
    speed <= 16'h9C4;
    near(16000, 2);
  endtask
  task t_accel;
    accel <= 16'h0;
    ctrl(7'h26);
    near(12000, 2);
    accel <= 16'h7D0;
    near(16000, 2);
    ctrl(7'h02);
    accel <= 16'h0;
    near(10000, 2);
    accel <= 16'hFA0;
    near(20000, 2);
    accel <= 16'hF060;
    near(0, 2);
  endtask
  task t_supp;
    ctrl(7'h11);
    rd(`SSOS_OFF_CTRL, 32'h41);
    speed <= 16'h0;
    ctrl(7'h15);
    rd(`SSOS_OFF_CTRL, 32'h55);
    near(4000, 2);
    wr(`SSOS_OFF_TAU, 32'h1);
    speed <= 16'hFA0;
    // Roughly 1024 filter updates make one time constant
    repeat (4096) @(posedge pclk);
    near(14116, 400);
    // Falling step: a quarter time constant leaves 78 % of the gap
    speed <= 16'h0;
    repeat (1018) @(posedge pclk);
    near(11878, 300);
    bp_voted <= 1'b0;
    near(0, 0);
    bp_voted <= 1'b1;
    ch_fault <= 1'b1;
    near(0, 0);
    ch_fault <= 1'b0;
  endtask
  // ========================================
  // Clock, reset, sequence
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pulse_in = 1'b0;
    bp_voted = 1'b0;
    ch_fault = 1'b0;
    speed = 16'h0;
    accel = 16'h0;
    err_count = 0;
    num_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_still();
    t_backplane();
    t_speed();
    t_cal();
    t_break();
    t_accel();
    t_supp();
    report_and_stop();
  end
  // Whole run needs well under 10000 cycles
  initial
  begin
    #(8 * 30000);
    err_count++;
    report_and_stop();
  end
endmodule // speed_current_output_scaler_bench
`default_nettype wire
